/* include/jip_defs.vh */
// jip_defs.vh: constants for the boundary-scan instruction port.
// assumes a 25 MHz system clock; included by bare name.
`ifndef JIP_DEFS_VH
`define JIP_DEFS_VH
`define JIP_IR_W          8
`define JIP_OP_BYPASS     8'hFF
`define JIP_OP_EXTEST     8'h00
`define JIP_OP_SAMPLE     8'h01
`define JIP_OP_CLAMP      8'hFA
`define JIP_OP_HIGHZ      8'hFC
`define JIP_OP_IDCODE     8'hFE
`define JIP_OP_USERCODE   8'hFD
`define JIP_OP_CONFIG     8'hEE
`define JIP_CAP_ISP_BIT   4
`define JIP_CAP_SEC_BIT   3
`define JIP_CAP_FIXED     2'b01
`define JIP_USERCODE_BLANK 32'hFFFF_FFFF
// arbitrary neutral identification value
`define JIP_IDCODE_VAL    32'h0000_0001
`define JIP_CLK_NS        40
`define JIP_CF_MIN_NS     300
`define JIP_CF_MAX_NS     500
// least time rounds up: ceil(300/40) = 8 cycles = 320 ns, within the 500 ns bound
`define JIP_CF_CYCLES     ((`JIP_CF_MIN_NS + `JIP_CLK_NS - 1) / `JIP_CLK_NS)
`endif

/* core/jip_tap.v */
// jip_tap.v: test access port with 8-bit instruction register, bypass,
// id/user code registers, read-security and config-request pulse.
// assumes tck, tms, tdi, oe/reset pin arrive asynchronously; all sampled on clk_in.
// What this block does
// - eight-bit instruction register between tdi and tdo
// - capture status pattern, shift out lsb first
// - captured bit 4 shows programming mode
// - captured bit 3 shows read security
// - captured bits 1:0 always 01
// - decode bypass, extest, sample/preload codes
// - decode clamp, idcode and usercode codes
// - highz code floats all outputs together
// - config code pulses config-request pin low
// - programming over the four-wire chainable port
// - outputs floated or clamped while programming
// - programming requires oe/reset pin driven low
// - oe/reset low resets counter, floats data
// - security bit blocks readout of pattern
// - security inhibits read/verify, allows program/erase
// - only full erase or rst_in clears security bit
// - same port for scan and programming
// - blank usercode reads all ones
`include "jip_defs.vh"
module jip_tap (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        tck_in,
  input  wire        tms_in,
  input  wire        tdi_in,
  input  wire        oe_reset_n_in,
  input  wire        isp_enter_in,
  input  wire        isp_exit_in,
  input  wire        sec_program_in,
  input  wire        full_erase_in,
  input  wire        usercode_load_in,
  input  wire [31:0] usercode_in,
  input  wire        read_req_in,
  input  wire        verify_req_in,
  output reg         tdo_out,
  output reg         tdo_oe_out,
  output reg         target_config_request_n_out,
  output reg         target_config_request_oe_out,
  output reg         outputs_highz_out,
  output reg         outputs_clamp_out,
  output reg         addr_reset_out,
  output reg         programming_mode_flag_out,
  output reg         read_security_out,
  output reg         read_grant_out,
  output reg         verify_grant_out,
  output reg  [7:0]  active_instr_out
);
  localparam [3:0] S_RESET = 4'h0, S_IDLE = 4'h1, S_DRSEL = 4'h2, S_DRCAP = 4'h3,
                   S_DRSH = 4'h4, S_DREX1 = 4'h5, S_DRPA = 4'h6, S_DREX2 = 4'h7,
                   S_DRUPD = 4'h8, S_IRSEL = 4'h9, S_IRCAP = 4'hA, S_IRSH = 4'hB,
                   S_IREX1 = 4'hC, S_IRPA = 4'hD, S_IREX2 = 4'hE, S_IRUPD = 4'hF;
  localparam [31:0] CF_CNT_FULL = `JIP_CF_CYCLES;
  localparam [3:0]  CF_CNT      = CF_CNT_FULL[3:0];

  // two-flop synchronisers; first stage read only by second stage
  reg [1:0] tck_s_q, tms_s_q, tdi_s_q, oe_s_q;
  reg       tck_d1_q;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tck_s_q  <= 2'b00;
      tms_s_q  <= 2'b11;
      tdi_s_q  <= 2'b11;
      oe_s_q   <= 2'b11;
      tck_d1_q <= 1'b0;
    end else begin
      tck_s_q  <= {tck_s_q[0], tck_in};
      tms_s_q  <= {tms_s_q[0], tms_in};
      tdi_s_q  <= {tdi_s_q[0], tdi_in};
      oe_s_q   <= {oe_s_q[0], oe_reset_n_in};
      tck_d1_q <= tck_s_q[1];
    end
  end
  wire tck_rise = tck_s_q[1] & ~tck_d1_q;
  wire tck_fall = ~tck_s_q[1] & tck_d1_q;
  wire tms = tms_s_q[1];
  wire tdi = tdi_s_q[1];

  reg [3:0]  st_q;
  reg [3:0]  st_d;
  reg [7:0]  instr_shift_reg_q;
  reg [7:0]  instr_q;
  reg [31:0] dr_q;
  reg        byp_q;
  reg [31:0] usercode_q;
  reg        isp_q;
  reg        sec_q;
  reg [3:0]  cf_cnt_q;

  // standard tap state walk, one step per tck rising edge
  always @* begin
    case (st_q)
      S_RESET: st_d = tms ? S_RESET : S_IDLE;
      S_IDLE:  st_d = tms ? S_DRSEL : S_IDLE;
      S_DRSEL: st_d = tms ? S_IRSEL : S_DRCAP;
      S_DRCAP: st_d = tms ? S_DREX1 : S_DRSH;
      S_DRSH:  st_d = tms ? S_DREX1 : S_DRSH;
      S_DREX1: st_d = tms ? S_DRUPD : S_DRPA;
      S_DRPA:  st_d = tms ? S_DREX2 : S_DRPA;
      S_DREX2: st_d = tms ? S_DRUPD : S_DRSH;
      S_DRUPD: st_d = tms ? S_DRSEL : S_IDLE;
      S_IRSEL: st_d = tms ? S_RESET : S_IRCAP;
      S_IRCAP: st_d = tms ? S_IREX1 : S_IRSH;
      S_IRSH:  st_d = tms ? S_IREX1 : S_IRSH;
      S_IREX1: st_d = tms ? S_IRUPD : S_IRPA;
      S_IRPA:  st_d = tms ? S_IREX2 : S_IRPA;
      S_IREX2: st_d = tms ? S_IRUPD : S_IRSH;
      S_IRUPD: st_d = tms ? S_DRSEL : S_IDLE;
      default: st_d = S_RESET;
    endcase
  end

  // capture image: status only in bits 4 and 3
  wire [7:0] cap_pat = {3'b000, isp_q, sec_q, 1'b0, `JIP_CAP_FIXED};

  wire is_byp  = (instr_q == `JIP_OP_BYPASS);
  wire is_id   = (instr_q == `JIP_OP_IDCODE);
  wire is_uc   = (instr_q == `JIP_OP_USERCODE);
  wire is_clmp = (instr_q == `JIP_OP_CLAMP);
  wire is_hz   = (instr_q == `JIP_OP_HIGHZ);
  wire is_cfg  = (instr_q == `JIP_OP_CONFIG);
  wire is_bsr  = (instr_q == `JIP_OP_EXTEST) || (instr_q == `JIP_OP_SAMPLE);
  // boundary cells live outside; other codes fall back to one-bit bypass
  wire use_dr32 = is_id | is_uc;
  wire use_byp  = ~use_dr32;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q              <= S_RESET;
      instr_shift_reg_q <= 8'h00;
      instr_q           <= `JIP_OP_IDCODE;
      dr_q              <= 32'h0000_0000;
      byp_q             <= 1'b0;
    end else if (tck_rise) begin
      st_q <= st_d;
      case (st_q)
        S_RESET: instr_q <= `JIP_OP_IDCODE;
        S_IRCAP: instr_shift_reg_q <= cap_pat;
        S_IRSH:  instr_shift_reg_q <= {tdi, instr_shift_reg_q[7:1]};
        S_IRUPD: instr_q <= instr_shift_reg_q;
        S_DRCAP: begin
          byp_q <= 1'b0;
          dr_q  <= is_id ? `JIP_IDCODE_VAL : usercode_q;
        end
        S_DRSH: begin
          byp_q <= tdi;
          dr_q  <= {tdi, dr_q[31:1]};
        end
        default: ;
      endcase
    end
  end

  // tdo changes on falling tck, driven only in shift states
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tdo_out    <= 1'b1;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_out <= (st_q == S_IRSH) || (st_q == S_DRSH);
      if (st_q == S_IRSH)
        tdo_out <= instr_shift_reg_q[0];
      else if (st_q == S_DRSH)
        tdo_out <= use_byp ? byp_q : dr_q[0];
      else
        tdo_out <= 1'b1;
    end
  end

  // mode, security and usercode storage
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      isp_q      <= 1'b0;
      sec_q      <= 1'b0;
      usercode_q <= `JIP_USERCODE_BLANK;
    end else begin
      // programming may only start with oe/reset held low
      if (isp_enter_in && !oe_s_q[1])
        isp_q <= 1'b1;
      else if (isp_exit_in)
        isp_q <= 1'b0;
      if (full_erase_in && isp_q) begin
        sec_q      <= 1'b0;
        usercode_q <= `JIP_USERCODE_BLANK;
      end else begin
        if (sec_program_in && isp_q)
          sec_q <= 1'b1;
        if (usercode_load_in && isp_q)
          usercode_q <= usercode_in;
      end
    end
  end

  // config pulse: counter started on entering run-idle with config loaded
  // the ir update edge still holds the old instruction, so look at the shifted code there
  wire cfg_fire = tck_rise && !tms &&
                  ((st_q == S_IRUPD && instr_shift_reg_q == `JIP_OP_CONFIG) ||
                   (st_q == S_DRUPD && is_cfg));
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cf_cnt_q                     <= 4'h0;
      // open-drain: level is always low, the enable alone makes the pulse
      target_config_request_n_out  <= 1'b0;
      target_config_request_oe_out <= 1'b0;
    end else begin
      if (cfg_fire)
        cf_cnt_q <= CF_CNT;
      else if (cf_cnt_q != 4'h0)
        cf_cnt_q <= cf_cnt_q - 4'h1;
      target_config_request_n_out  <= 1'b0;
      target_config_request_oe_out <= cfg_fire || (cf_cnt_q > 4'h1);
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      outputs_highz_out         <= 1'b1;
      outputs_clamp_out         <= 1'b0;
      addr_reset_out            <= 1'b1;
      programming_mode_flag_out <= 1'b0;
      read_security_out         <= 1'b0;
      read_grant_out            <= 1'b0;
      verify_grant_out          <= 1'b0;
      active_instr_out          <= `JIP_OP_IDCODE;
    end else begin
      // clamp wins over the programming float; programming otherwise floats outputs
      outputs_clamp_out <= is_clmp;
      outputs_highz_out <= is_hz || !oe_s_q[1] || (isp_q && !is_clmp) || is_bsr;
      addr_reset_out    <= !oe_s_q[1];
      programming_mode_flag_out <= isp_q;
      read_security_out <= sec_q;
      read_grant_out    <= read_req_in && !sec_q;
      verify_grant_out  <= verify_req_in && !sec_q;
      active_instr_out  <= instr_q;
    end
  end
endmodule

/* testbench/jip_tap_sva.sv */
// jip_tap_sva.sv: port assertions for jip_tap.
// assumes the 25 MHz clk_in and the async active-high rst_in of the block.
`include "jip_defs.vh"
module jip_tap_sva (
  input wire       clk_in,
  input wire       rst_in,
  input wire       oe_reset_n_in,
  input wire       target_config_request_n_out,
  input wire       target_config_request_oe_out,
  input wire       outputs_highz_out,
  input wire       outputs_clamp_out,
  input wire       addr_reset_out,
  input wire       programming_mode_flag_out,
  input wire       read_security_out,
  input wire       read_grant_out,
  input wire       verify_grant_out,
  input wire [7:0] active_instr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // 8 cycles of 40 ns sits inside the 300 to 500 ns window
  sequence cf_hold;
    target_config_request_oe_out [*8] ##1 !target_config_request_oe_out;
  endsequence
  cf_level_a: assert property (target_config_request_n_out == 1'b0)
    else $error("config request drives high");
  cf_width_a: assert property ($rose(target_config_request_oe_out) |-> cf_hold)
    else $error("config pulse width wrong");
  cf_cause_a: assert property ($rose(target_config_request_oe_out) |->
    ##1 active_instr_out == `JIP_OP_CONFIG) else $error("config pulse without config code");
  highz_all_a: assert property (active_instr_out == `JIP_OP_HIGHZ &&
    $past(active_instr_out) == `JIP_OP_HIGHZ |-> outputs_highz_out) else $error("highz lost");
  isp_float_a: assert property (programming_mode_flag_out &&
    $past(programming_mode_flag_out) |-> outputs_highz_out || outputs_clamp_out)
    else $error("outputs driven in programming mode");
  isp_entry_a: assert property ($rose(programming_mode_flag_out) |-> addr_reset_out)
    else $error("programming entered with oe high");
  oe_reset_a: assert property ($fell(oe_reset_n_in) |-> ##[1:4] addr_reset_out)
    else $error("address counter not reset");
  read_block_a: assert property (read_security_out && $past(read_security_out)
    |-> !read_grant_out && !verify_grant_out) else $error("read granted while secured");
endmodule
bind jip_tap jip_tap_sva u_sva (.*);

/* testbench/jip_jtag_ctl.sv */
// jip_jtag_ctl.sv: behavioural test controller on the four-wire port.
// assumes clk_in is 40 ns; tck is 320 ns and rests low between frames.
module jip_jtag_ctl (
  input  wire logic clk_in,
  input  wire logic tdo_in,
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // tdo is taken just before the rising edge, where it has long settled
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    repeat (4) @(negedge clk_in);
    tdo = tdo_in;
    tck_out = 1'b1;
    repeat (4) @(negedge clk_in);
    tck_out = 1'b0;
  endtask
  // from idle: select, capture, shift n bits lsb first, update, idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask
endmodule

/* testbench/jip_tap_tb.sv */
// jip_tap_tb.sv: self-checking bench for jip_tap.
// assumes jip_defs.vh on the include path; checker bound by its own file.
`include "jip_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0, rst_in = 1'b1, tck_in, tms_in, tdi_in, oe_reset_n_in = 1'b1;
  logic        isp_enter_in = 1'b0, isp_exit_in = 1'b0, sec_program_in = 1'b0, t;
  logic        full_erase_in = 1'b0, usercode_load_in = 1'b0, read_req_in = 1'b0;
  logic [31:0] usercode_in = 32'h1234_5678, d;
  wire         verify_req_in = read_req_in;
  logic        tdo_out, tdo_oe_out, target_config_request_n_out, target_config_request_oe_out;
  logic        outputs_highz_out, outputs_clamp_out, addr_reset_out, programming_mode_flag_out;
  logic        read_security_out, read_grant_out, verify_grant_out;
  logic [7:0]  active_instr_out;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, cf_cycles = 0;
  logic [7:0]  ops [9] = '{8'hFF, 8'h00, 8'h01, 8'hFA, 8'hFC, 8'hFE, 8'hFD, 8'hEE, 8'h5A};
  // tdo has a pull-up when not driven
  wire         tdo_w = tdo_oe_out ? tdo_out : 1'b1;
  jip_tap u_jip_tap (.*);
  jip_jtag_ctl u_jip_jtag_ctl (.clk_in(clk_in), .tdo_in(tdo_w), .tck_out(tck_in),
                               .tms_out(tms_in), .tdi_out(tdi_in));
  always #20 clk_in = ~clk_in;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_in);
    s = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge clk_in) begin
    if (target_config_request_oe_out === 1'b1) cf_cycles++;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    u_jip_jtag_ctl.step(1'b0, 1'b1, t);
    u_jip_jtag_ctl.scan(1'b0, 32, 32'h0, d);
    chk("idcode", `JIP_IDCODE_VAL, d);
    foreach (ops[i]) begin
      u_jip_jtag_ctl.scan(1'b1, 8, {24'h0, ops[i]}, d);
      chk("capture", 32'h0000_0001, d);
      chk("instr", {24'h0, ops[i]}, {24'h0, active_instr_out});
      if (ops[i] == 8'hFC) chk("highz", 32'h1, 32'(outputs_highz_out));
      if (ops[i] == 8'hFA) chk("clamp", 32'h1, 32'(outputs_clamp_out));
      if (ops[i] == 8'hEE) chk("cf_pulse", 32'h2, {30'h0, target_config_request_oe_out,
                               target_config_request_n_out});
    end
    u_jip_jtag_ctl.scan(1'b0, 8, 32'h0000_00A5, d);
    chk("bypass", 32'h0000_004A, d);
    u_jip_jtag_ctl.scan(1'b1, 8, 32'h0000_00FD, d);
    u_jip_jtag_ctl.scan(1'b0, 32, 32'h0, d);
    chk("usercode", `JIP_USERCODE_BLANK, d);
    oe_reset_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("addr_reset", 32'h1, 32'(addr_reset_out));
    pulse(isp_enter_in);
    chk("isp_flag", 32'h1, 32'(programming_mode_flag_out));
    pulse(sec_program_in);
    read_req_in = 1'b1;
    u_jip_jtag_ctl.scan(1'b1, 8, 32'h0000_00FD, d);
    chk("capture_isp", 32'h0000_0019, d);
    chk("isp_highz", 32'h1, 32'(outputs_highz_out));
    chk("grant_sec", 32'h0, {30'h0, read_grant_out, verify_grant_out});
    pulse(full_erase_in);
    chk("sec_erased", 32'h0, 32'(read_security_out));
    chk("grant_open", 32'h3, {30'h0, read_grant_out, verify_grant_out});
    pulse(usercode_load_in);
    u_jip_jtag_ctl.scan(1'b0, 32, 32'h0, d);
    chk("usercode_load", 32'h1234_5678, d);
    pulse(isp_exit_in);
    oe_reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk("isp_flag_off", 32'h0, 32'(programming_mode_flag_out));
    u_jip_jtag_ctl.scan(1'b1, 8, 32'h0000_00FF, d);
    chk("capture_user", 32'h0000_0001, d);
    chk("cf_cycles", `JIP_CF_CYCLES, cf_cycles);
    results();
  end
endmodule
